//--- include/flash_host_pkg.sv
// constants and types for the host-side controller of a byte-wide flash
package flash_host_pkg;
    // ---------------------------------------------------------------
    // widths and timing
    // ---------------------------------------------------------------
    localparam int ADDR_W       = 18;
    localparam int DATA_W       = 8;
    localparam int CLK_MHZ      = 200;
    localparam int POWERUP_MS   = 5;
    localparam int POWERUP_CYC  = POWERUP_MS * CLK_MHZ * 1000;
    localparam int SETUP_NS     = 20;
    localparam int STROBE_NS    = 100;
    localparam int RECOV_NS     = 20;
    localparam int SYNC_STAGES  = 2;
    localparam int SETUP_CYC    = (SETUP_NS * CLK_MHZ + 999) / 1000;
    localparam int STROBE_CYC   = (STROBE_NS * CLK_MHZ + 999) / 1000;
    localparam int RD_STROBE_CYC = STROBE_CYC + SYNC_STAGES;
    localparam int RECOV_CYC    = (RECOV_NS * CLK_MHZ + 999) / 1000;
    localparam int CNT_W        = 5;
    localparam int PWR_W        = 21;
    // ---------------------------------------------------------------
    // command words
    // ---------------------------------------------------------------
    localparam logic [14:0] UNLOCK_A1  = 15'h5555;
    localparam logic [14:0] UNLOCK_A2  = 15'h2AAA;
    localparam logic [7:0]  UNLOCK_D1  = 8'hAA;
    localparam logic [7:0]  UNLOCK_D2  = 8'h55;
    localparam logic [7:0]  CMD_PROG   = 8'hA0;
    localparam logic [7:0]  CMD_SETUP  = 8'h80;
    localparam logic [7:0]  CMD_CHIP   = 8'h10;
    localparam logic [7:0]  CMD_SECT   = 8'h30;
    localparam logic [7:0]  CMD_PAGE   = 8'h50;
    localparam logic [7:0]  CMD_ID_IN  = 8'h90;
    localparam logic [7:0]  CMD_ID_OUT = 8'hF0;
    localparam logic [2:0]  PROG_LAST  = 3'h3;
    localparam logic [2:0]  ERASE_LAST = 3'h5;
    localparam logic [2:0]  ID_LAST    = 3'h2;
    localparam int          POLL_BIT   = 7;
    localparam int          TOGGLE_BIT = 6;
    localparam logic [7:0]  BYTE_ZERO  = 8'h00;
    localparam logic [17:0] ADDR_ZERO  = 18'h0_0000;
    // ---------------------------------------------------------------
    // user orders
    // ---------------------------------------------------------------
    typedef enum logic [2:0] {
        OP_READ   = 3'b000,
        OP_PROG   = 3'b001,
        OP_CHIP   = 3'b010,
        OP_SECT   = 3'b011,
        OP_PAGE   = 3'b100,
        OP_ID_IN  = 3'b101,
        OP_ID_OUT = 3'b110
    } op_type;
endpackage : flash_host_pkg

//--- rtl/flash_pin_cycle.sv
// one read or write bus cycle on the flash pins
`timescale 1ns/1ps
module flash_pin_cycle (
    input  wire logic                              i_core_clk,
    input  wire logic                              i_nrst,
    input  wire logic                              i_start,
    input  wire logic                              i_write,
    input  wire logic [flash_host_pkg::ADDR_W-1:0] i_addr,
    input  wire logic [flash_host_pkg::DATA_W-1:0] i_data,
    input  wire logic [flash_host_pkg::DATA_W-1:0] i_dq_in,
    output logic                                   o_ce_n,
    output logic                                   o_oe_n,
    output logic                                   o_we_n,
    output logic [flash_host_pkg::ADDR_W-1:0]      o_addr,
    output logic [flash_host_pkg::DATA_W-1:0]      o_dq_out,
    output logic                                   o_dq_oe,
    output logic [flash_host_pkg::DATA_W-1:0]      o_rdata,
    output logic                                   o_done
);
    import flash_host_pkg::*;

    typedef enum logic [1:0] {
        PH_IDLE   = 2'b00,
        PH_SETUP  = 2'b01,
        PH_STROBE = 2'b10,
        PH_HOLD   = 2'b11
    } phase_type;

    typedef struct packed {
        phase_type         phase;
        logic [CNT_W-1:0]  cnt;
        logic              wr;
        logic              ce_n;
        logic              oe_n;
        logic              we_n;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] dq_out;
        logic              dq_oe;
        logic [DATA_W-1:0] sync1;
        logic [DATA_W-1:0] sync2;
        logic [DATA_W-1:0] rdata;
        logic              done;
    } cyc_type;

    cyc_type s_reg;
    cyc_type s_next;

    // ---------------------------------------------------------------
    // phase sequencing
    // ---------------------------------------------------------------
    always_comb begin
        s_next       = s_reg;
        s_next.sync1 = i_dq_in;
        s_next.sync2 = s_reg.sync1;
        s_next.done  = 1'b0;
        case (s_reg.phase)
            PH_IDLE: begin
                if (i_start) begin
                    s_next.wr     = i_write;
                    s_next.addr   = i_addr;
                    s_next.dq_out = i_data;
                    s_next.dq_oe  = i_write;
                    s_next.ce_n   = 1'b0;
                    s_next.cnt    = CNT_W'(SETUP_CYC - 1);
                    s_next.phase  = PH_SETUP;
                end
            end
            PH_SETUP: begin
                if (s_reg.cnt == '0) begin
                    // write keeps output enable high while strobing
                    if (s_reg.wr) begin
                        s_next.we_n = 1'b0;
                        s_next.cnt  = CNT_W'(STROBE_CYC - 1);
                    end else begin
                        s_next.oe_n = 1'b0;
                        s_next.cnt  = CNT_W'(RD_STROBE_CYC - 1);
                    end
                    s_next.phase = PH_STROBE;
                end else begin
                    s_next.cnt = s_reg.cnt - 1'b1;
                end
            end
            PH_STROBE: begin
                if (s_reg.cnt == '0) begin
                    if (!s_reg.wr) begin
                        s_next.rdata = s_reg.sync2;
                    end
                    s_next.we_n  = 1'b1;
                    s_next.oe_n  = 1'b1;
                    s_next.cnt   = CNT_W'(RECOV_CYC - 1);
                    s_next.phase = PH_HOLD;
                end else begin
                    s_next.cnt = s_reg.cnt - 1'b1;
                end
            end
            PH_HOLD: begin
                if (s_reg.cnt == '0) begin
                    s_next.ce_n  = 1'b1;
                    s_next.dq_oe = 1'b0;
                    s_next.done  = 1'b1;
                    s_next.phase = PH_IDLE;
                end else begin
                    s_next.cnt = s_reg.cnt - 1'b1;
                end
            end
            default: begin
                s_next.phase = PH_IDLE;
            end
        endcase
    end

    // state register
    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            s_reg <= '{phase: PH_IDLE, cnt: '0, wr: 1'b0, ce_n: 1'b1, oe_n: 1'b1,
                       we_n: 1'b1, addr: ADDR_ZERO, dq_out: BYTE_ZERO, dq_oe: 1'b0,
                       sync1: BYTE_ZERO, sync2: BYTE_ZERO, rdata: BYTE_ZERO,
                       done: 1'b0};
        end else begin
            s_reg <= s_next;
        end
    end

    assign o_ce_n   = s_reg.ce_n;
    assign o_oe_n   = s_reg.oe_n;
    assign o_we_n   = s_reg.we_n;
    assign o_addr   = s_reg.addr;
    assign o_dq_out = s_reg.dq_out;
    assign o_dq_oe  = s_reg.dq_oe;
    assign o_rdata  = s_reg.rdata;
    assign o_done   = s_reg.done;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_nrst);

    sequence strobe_low_s;
        !o_we_n [*8];
    endsequence

    AST_WRITE_LEVELS: assert property (!o_we_n |-> !o_ce_n && o_oe_n && o_dq_oe)
        else $error("write strobe low without select, with output enable, or undriven");
    AST_WRITE_WIDTH: assert property ($fell(o_we_n) |-> strobe_low_s)
        else $error("write strobe pulse too short");
endmodule : flash_pin_cycle

//--- rtl/flash_host_ctrl.sv
// host controller issuing command sequences and status polling to a flash
`timescale 1ns/1ps
module flash_host_ctrl #(
    parameter int POWERUP_CYCLES = flash_host_pkg::POWERUP_CYC
) (
    input  wire logic                              i_core_clk,
    input  wire logic                              i_nrst,
    input  wire logic                              i_cmd_valid,
    input  wire flash_host_pkg::op_type            i_cmd,
    input  wire logic [flash_host_pkg::ADDR_W-1:0] i_addr,
    input  wire logic [flash_host_pkg::DATA_W-1:0] i_wdata,
    output logic                                   o_cmd_ready,
    output logic                                   o_done,
    output logic                                   o_fail,
    output logic [flash_host_pkg::DATA_W-1:0]      o_rdata,
    output logic                                   o_id_mode,
    output logic                                   o_flash_ce_n,
    output logic                                   o_flash_oe_n,
    output logic                                   o_flash_we_n,
    output logic [flash_host_pkg::ADDR_W-1:0]      o_flash_addr,
    output logic [flash_host_pkg::DATA_W-1:0]      o_flash_dq_out,
    output logic                                   o_flash_dq_oe,
    input  wire logic [flash_host_pkg::DATA_W-1:0] i_flash_dq_in
);
    import flash_host_pkg::*;

    typedef enum logic [2:0] {
        ST_PWRUP  = 3'b000,
        ST_IDLE   = 3'b001,
        ST_SEQ_W  = 3'b010,
        ST_POLL_W = 3'b011,
        ST_LAST_W = 3'b100,
        ST_READ_W = 3'b101
    } state_type;

    typedef struct packed {
        state_type         state;
        logic [PWR_W-1:0]  pwr_cnt;
        logic [2:0]        step;
        op_type            op;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic [DATA_W-1:0] prev;
        logic              first;
        logic              start;
        logic              write;
        logic [ADDR_W-1:0] cyc_addr;
        logic [DATA_W-1:0] cyc_data;
        logic              ready;
        logic              done;
        logic              fail;
        logic [DATA_W-1:0] rdata;
        logic              id_mode;
    } ctrl_type;

    ctrl_type s_reg;
    ctrl_type s_next;

    logic              cyc_done;
    logic [DATA_W-1:0] cyc_rdata;
    logic [2:0]        last_step;
    logic [25:0]       word;

    // bus cycle engine on the pins
    flash_pin_cycle u_cycle (
        .i_core_clk (i_core_clk),
        .i_nrst     (i_nrst),
        .i_start    (s_reg.start),
        .i_write    (s_reg.write),
        .i_addr     (s_reg.cyc_addr),
        .i_data     (s_reg.cyc_data),
        .i_dq_in    (i_flash_dq_in),
        .o_ce_n     (o_flash_ce_n),
        .o_oe_n     (o_flash_oe_n),
        .o_we_n     (o_flash_we_n),
        .o_addr     (o_flash_addr),
        .o_dq_out   (o_flash_dq_out),
        .o_dq_oe    (o_flash_dq_oe),
        .o_rdata    (cyc_rdata),
        .o_done     (cyc_done)
    );

    // address and data of one write of a command sequence
    function automatic logic [25:0] step_word(input op_type op, input logic [2:0] step,
                                              input logic [ADDR_W-1:0] a,
                                              input logic [DATA_W-1:0] d);
        logic [25:0] w;
        w = {3'b000, UNLOCK_A1, UNLOCK_D1};
        case (step)
            3'h1: w = {3'b000, UNLOCK_A2, UNLOCK_D2};
            3'h2: begin
                case (op)
                    OP_PROG:   w = {3'b000, UNLOCK_A1, CMD_PROG};
                    OP_ID_IN:  w = {3'b000, UNLOCK_A1, CMD_ID_IN};
                    OP_ID_OUT: w = {3'b000, UNLOCK_A1, CMD_ID_OUT};
                    default:   w = {3'b000, UNLOCK_A1, CMD_SETUP};
                endcase
            end
            3'h3: w = (op == OP_PROG) ? {a, d} : {3'b000, UNLOCK_A1, UNLOCK_D1};
            3'h4: w = {3'b000, UNLOCK_A2, UNLOCK_D2};
            3'h5: begin
                case (op)
                    OP_SECT: w = {a, CMD_SECT};
                    OP_PAGE: w = {a, CMD_PAGE};
                    default: w = {3'b000, UNLOCK_A1, CMD_CHIP};
                endcase
            end
            default: w = {3'b000, UNLOCK_A1, UNLOCK_D1};
        endcase
        return w;
    endfunction : step_word

    // last write index of each sequence
    always_comb begin
        case (s_reg.op)
            OP_PROG:                   last_step = PROG_LAST;
            OP_CHIP, OP_SECT, OP_PAGE: last_step = ERASE_LAST;
            default:                   last_step = ID_LAST;
        endcase
    end

    assign word = step_word(s_reg.op, s_reg.step + 3'h1, s_reg.addr, s_reg.wdata); // next write

    // ---------------------------------------------------------------
    // sequencer
    // ---------------------------------------------------------------
    always_comb begin
        s_next       = s_reg;
        s_next.start = 1'b0;
        s_next.done  = 1'b0;
        s_next.ready = 1'b0;
        case (s_reg.state)
            ST_PWRUP: begin
                // no command write until the power-up delay has run out
                if (s_reg.pwr_cnt == PWR_W'(POWERUP_CYCLES - 1)) begin
                    s_next.state = ST_IDLE;
                    s_next.ready = 1'b1;
                end else begin
                    s_next.pwr_cnt = s_reg.pwr_cnt + 1'b1;
                end
            end
            ST_IDLE: begin
                s_next.ready = 1'b1;
                if (i_cmd_valid && s_reg.ready) begin
                    s_next.ready    = 1'b0;
                    s_next.op       = i_cmd;
                    s_next.addr     = i_addr;
                    s_next.wdata    = i_wdata;
                    s_next.step     = 3'h0;
                    s_next.fail     = 1'b0;
                    s_next.first    = 1'b1;
                    s_next.start    = 1'b1;
                    s_next.cyc_addr = i_addr;
                    s_next.cyc_data = UNLOCK_D1;
                    s_next.write    = (i_cmd != OP_READ);
                    s_next.state    = (i_cmd == OP_READ) ? ST_READ_W : ST_SEQ_W;
                    if (i_cmd != OP_READ) begin
                        s_next.cyc_addr = {3'b000, UNLOCK_A1};
                    end
                end
            end
            ST_SEQ_W: begin
                s_next.cyc_addr = word[25:8];
                s_next.cyc_data = word[7:0];
                if (cyc_done) begin
                    if (s_reg.step == last_step) begin
                        // status reads go to the target address
                        s_next.write    = 1'b0;
                        s_next.cyc_addr = s_reg.addr;
                        if (s_reg.op == OP_ID_IN || s_reg.op == OP_ID_OUT) begin
                            s_next.id_mode = (s_reg.op == OP_ID_IN);
                            s_next.done    = 1'b1;
                            s_next.state   = ST_IDLE;
                        end else begin
                            s_next.start = 1'b1;
                            s_next.state = ST_POLL_W;
                        end
                    end else begin
                        s_next.step  = s_reg.step + 1'b1;
                        s_next.start = 1'b1;
                    end
                end
                if (s_reg.start) begin
                    s_next.cyc_addr = s_reg.cyc_addr;
                    s_next.cyc_data = s_reg.cyc_data;
                end
            end
            ST_POLL_W: begin
                if (cyc_done) begin
                    s_next.prev  = cyc_rdata;
                    s_next.first = 1'b0;
                    s_next.start = 1'b1;
                    // toggle bit at rest: read once more for a whole valid byte
                    if (!s_reg.first && (s_reg.prev[TOGGLE_BIT] == cyc_rdata[TOGGLE_BIT])) begin
                        s_next.state = ST_LAST_W;
                    end
                end
            end
            ST_LAST_W: begin
                if (cyc_done) begin
                    s_next.rdata = cyc_rdata;
                    s_next.done  = 1'b1;
                    s_next.state = ST_IDLE;
                    if (s_reg.op == OP_PROG) begin
                        s_next.fail = (cyc_rdata != s_reg.wdata);
                    end else begin
                        s_next.fail = !cyc_rdata[POLL_BIT];
                    end
                end
            end
            ST_READ_W: begin
                if (cyc_done) begin
                    s_next.rdata = cyc_rdata;
                    s_next.done  = 1'b1;
                    s_next.state = ST_IDLE;
                end
            end
            default: begin
                s_next.state = ST_IDLE;
            end
        endcase
    end

    // state register
    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            s_reg <= '{state: ST_PWRUP, pwr_cnt: '0, step: 3'h0, op: OP_READ,
                       addr: ADDR_ZERO, wdata: BYTE_ZERO, prev: BYTE_ZERO, first: 1'b1,
                       start: 1'b0, write: 1'b0, cyc_addr: ADDR_ZERO,
                       cyc_data: BYTE_ZERO, ready: 1'b0, done: 1'b0, fail: 1'b0,
                       rdata: BYTE_ZERO, id_mode: 1'b0};
        end else begin
            s_reg <= s_next;
        end
    end

    assign o_cmd_ready = s_reg.ready;
    assign o_done      = s_reg.done;
    assign o_fail      = s_reg.fail;
    assign o_rdata     = s_reg.rdata;
    assign o_id_mode   = s_reg.id_mode;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_nrst);

    sequence seq_write_s;
        s_reg.state == ST_SEQ_W && s_reg.start;
    endsequence

    AST_PWRUP_QUIET: assert property (s_reg.state == ST_PWRUP |-> o_flash_ce_n && o_flash_we_n)
        else $error("flash touched during power-up delay");
    AST_PWRUP_LEN: assert property ($fell(s_reg.state == ST_PWRUP) |->
                                    s_reg.pwr_cnt == PWR_W'(POWERUP_CYCLES - 1))
        else $error("power-up delay left early");
    AST_PROG_FOURTH: assert property (seq_write_s and s_reg.op == OP_PROG && s_reg.step == 3'h3
                                      |-> s_reg.cyc_addr == s_reg.addr
                                          && s_reg.cyc_data == s_reg.wdata)
        else $error("program fourth write lacks target address or data");
    AST_ERASE_SIXTH: assert property (seq_write_s and s_reg.op == OP_CHIP && s_reg.step == 3'h5
                                      |-> s_reg.cyc_data == CMD_CHIP)
        else $error("chip erase sixth write wrong");
    AST_POLL_ADDR: assert property (s_reg.state == ST_POLL_W && !o_flash_oe_n
                                    |-> o_flash_addr == s_reg.addr)
        else $error("status read not at target address");
    AST_ID_EXIT: assert property ($fell(s_reg.id_mode) |-> $past(s_reg.op) == OP_ID_OUT)
        else $error("identification mode left without exit sequence");
    AST_FULL_REREAD: assert property (s_reg.done && s_reg.op inside {OP_PROG, OP_CHIP}
                                      |-> $past(s_reg.state) == ST_LAST_W)
        else $error("embedded result reported without a final read");
    AST_UNLOCK_LOW: assert property (seq_write_s and s_reg.step < 3'h3
                                     |-> s_reg.cyc_addr[17:15] == 3'b000)
        else $error("unlock write carries upper address bits");
    AST_NO_OE_WRITE: assert property (!o_flash_we_n |=> o_flash_oe_n)
        else $error("output enable low right after a write strobe");
endmodule : flash_host_ctrl

//--- bench/flash_dev_model.sv
// behavioural flash device on the far side of the controller pins
`timescale 1ns/1ps
module flash_dev_model #(
    parameter logic [7:0] MAKER   = 8'h3C, // arbitrary value
    parameter logic [7:0] DEVICE  = 8'h4B, // arbitrary value
    parameter int         BUSY_RD = 3
) (
    input  wire logic        i_ce_n,
    input  wire logic        i_oe_n,
    input  wire logic        i_we_n,
    input  wire logic [17:0] i_a,
    input  wire logic [7:0]  i_d,
    output logic [7:0]       o_q
);
    logic [7:0] mem [logic [17:0]];
    logic [7:0] rd = 8'h00, lw = 8'h00;
    logic       id = 1'b0, tg = 1'b0, er = 1'b0;
    int         st = 0, busy = 0;
    function automatic logic [7:0] arr(input logic [17:0] x);
        return mem.exists(x) ? mem[x] : 8'hFF;
    endfunction : arr
    // command decode on strobe rise, refused while busy
    always @(posedge i_we_n) begin
        logic u1, u2, c5;
        int   n;
        u1 = i_a[14:0] == 15'h5555 && i_d == 8'hAA;
        u2 = i_a[14:0] == 15'h2AAA && i_d == 8'h55;
        c5 = i_a[14:0] == 15'h5555;
        n  = 0;
        if (!i_ce_n && i_oe_n && busy == 0) begin
            if (st == 0 || st == 4) n = u1 ? st + 1 : 0;
            if (st == 1 || st == 5) n = u2 ? st + 1 : 0;
            if (st == 2 && c5) n = i_d == 8'hA0 ? 3 : i_d == 8'h80 ? 4 : 0;
            if (st == 2 && c5 && i_d == 8'h90) id = 1;
            if (i_d == 8'hF0 && (st == 0 || st == 2 && c5)) id = 0;
            if (st == 3) begin
                lw = i_d;
                er = 0;
                busy = (i_d & ~arr(i_a)) != 0 ? 0 : BUSY_RD;
                mem[i_a] = arr(i_a) & i_d;
            end
            if (st == 6 && i_d inside {8'h10, 8'h30, 8'h50}) begin
                er = 1;
                busy = BUSY_RD;
                foreach (mem[k])
                    if (i_d == 8'h10 || i_d == 8'h30 && k[17:16] == i_a[17:16]
                        || i_d == 8'h50 && k[17:12] == i_a[17:12]) mem[k] = 8'hFF;
            end
            st = n;
        end
    end
    // status while busy, else array or codes
    always @(negedge i_oe_n or negedge i_ce_n) begin
        if (!i_ce_n && !i_oe_n) begin
            if (busy > 0) begin
                tg = ~tg;
                busy = busy - 1;
                rd = {er ? 1'b0 : ~lw[7], tg, lw[5:0]};
            end else if (id && i_a[7:1] == 7'h00) rd = i_a[0] ? DEVICE : MAKER;
            else rd = arr(i_a);
        end
    end
    assign o_q = (!i_ce_n && !i_oe_n) ? rd : ~rd;
endmodule : flash_dev_model

//--- bench/testbench.sv
// self-checking bench for the flash host controller
`timescale 1ns/1ps
module testbench;
    import flash_host_pkg::*;
    logic i_core_clk = 0, i_nrst = 0, i_cmd_valid = 0, ce_n, oe_n, we_n, dq_oe;
    logic o_cmd_ready, o_done, o_fail, o_id_mode;
    logic [17:0] i_addr = 0, fa;
    logic [7:0] i_wdata = 0, o_rdata, dq_out, mq;
    op_type i_cmd = OP_READ;
    wire logic [7:0] dq = dq_oe ? dq_out : mq;
    int error_cnt = 0, n_checks = 0;
    flash_host_ctrl #(.POWERUP_CYCLES(20)) dut (.i_core_clk(i_core_clk), .i_nrst(i_nrst),
        .i_cmd_valid(i_cmd_valid), .i_cmd(i_cmd), .i_addr(i_addr), .i_wdata(i_wdata),
        .o_cmd_ready(o_cmd_ready), .o_done(o_done), .o_fail(o_fail), .o_rdata(o_rdata),
        .o_id_mode(o_id_mode), .o_flash_ce_n(ce_n), .o_flash_oe_n(oe_n), .o_flash_we_n(we_n),
        .o_flash_addr(fa), .o_flash_dq_out(dq_out), .o_flash_dq_oe(dq_oe), .i_flash_dq_in(dq));
    flash_dev_model dev (.i_ce_n(ce_n), .i_oe_n(oe_n), .i_we_n(we_n), .i_a(fa), .i_d(dq),
        .o_q(mq));
    initial forever #2.5 i_core_clk = ~i_core_clk;
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : tally_and_finish
    // one order, bounded waits for ready and done
    task automatic op(input op_type c, input logic [17:0] a, input logic [7:0] d);
        for (int k = 0; !o_cmd_ready; k++) begin
            if (k > 100) begin error_cnt++; tally_and_finish(); end
            @(negedge i_core_clk);
        end
        i_cmd = c;
        i_addr = a;
        i_wdata = d;
        i_cmd_valid = 1;
        @(negedge i_core_clk);
        i_cmd_valid = 0;
        for (int k = 0; !o_done; k++) begin
            if (k > 3000) begin error_cnt++; tally_and_finish(); end
            @(negedge i_core_clk);
        end
    endtask : op
    always @(negedge we_n) chk("write pins", 8'h01, {ce_n, oe_n});
    task automatic t_power;
        int k;
        for (k = 0; !o_cmd_ready && k < 200; k++) @(negedge i_core_clk);
        chk("powerup", 1, k >= 20 && k < 200);
        $display("t_power done");
    endtask : t_power
    task automatic t_prog;
        op(OP_PROG, 18'h1_2345, 8'h5A);
        chk("prog fail", 0, o_fail);
        chk("prog byte", 8'h5A, o_rdata);
        op(OP_READ, 18'h1_2345, 0);
        chk("readback", 8'h5A, o_rdata);
        op(OP_PROG, 18'h1_2345, 8'hFF);
        chk("restore fail", 1, o_fail);
        $display("t_prog done");
    endtask : t_prog
    task automatic t_erase;
        op(OP_PROG, 18'h2_0010, 8'h00);
        op(OP_PAGE, 18'h2_1000, 0);
        chk("page fail", 0, o_fail);
        op(OP_READ, 18'h2_0010, 0);
        chk("other page", 8'h00, o_rdata);
        op(OP_SECT, 18'h1_0000, 0);
        op(OP_READ, 18'h1_2345, 0);
        chk("sector", 8'hFF, o_rdata);
        op(OP_CHIP, 18'h2_0010, 0);
        op(OP_READ, 18'h2_0010, 0);
        chk("chip", 8'hFF, o_rdata);
        $display("t_erase done");
    endtask : t_erase
    task automatic t_id;
        op(OP_ID_IN, 0, 0);
        chk("id on", 1, o_id_mode);
        op(OP_READ, 0, 0);
        chk("maker", 8'h3C, o_rdata);
        op(OP_READ, 1, 0);
        chk("device", 8'h4B, o_rdata);
        op(OP_ID_OUT, 0, 0);
        chk("id off", 0, o_id_mode);
        op(OP_READ, 1, 0);
        chk("array", 8'hFF, o_rdata);
        $display("t_id done");
    endtask : t_id
    initial begin
        repeat (2) @(negedge i_core_clk);
        i_nrst = 1;
        t_power();
        t_prog();
        t_erase();
        t_id();
        tally_and_finish();
    end
endmodule : testbench
